// [rtl/dswi_core.sv]
// Control word decode, drive state machine, status word and emergencies
//
// Functional notes
// - Negative modes vendor; 1..10 defined; 5 and 11 up reserved.
// - Mode selector zero means no operating mode assigned.
// - Decode control bits 7,3,2,1,0 into drive state commands.
// - Switch-on-and-enable in ready performs switch-on, then enables.
// - After switched-on actions the combined command enters operation.
// - Status word bits 6,5,3..0 encode the current drive state.
// - Each fault emits code, error register and fault number.
// - Error register bit 0 set on any fault, clear when none.
// - Register bits 1..5 flag current, voltage, temp, comm, profile.
// - Codes for no fault, short, bus overvoltage and regeneration.
// - Codes for three overtemperatures, encoder and resolver faults.
`include "dswi_defs.svh"

module dswi_core #(
	parameter int NUM_FAULTS = `DSWI_NUM_FAULTS
) (
	input wire logic clock, // 250 MHz clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic [15:0] control_word, // Control word from master
	input wire logic cw_strobe, // Control word written this cycle
	input wire logic signed [7:0] mode_sel, // Operation mode selector
	input wire logic [NUM_FAULTS-1:0] fault_in, // Detected faults, 1..8
	input wire logic power_ready, // Power stage ready, leaves not-ready
	input wire logic reaction_done, // Fault reaction finished
	output logic [15:0] status_word, // Status word to master
	output dswi_pkg::dswi_state_type drive_state, // Current state
	output dswi_pkg::dswi_mode_info_type mode_info, // Mode class flags
	output dswi_pkg::dswi_emcy_type emcy, // Emergency message
	output logic emcy_valid // One-cycle pulse with each emergency
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------

	// Emergency content of one fault index
	function automatic dswi_pkg::dswi_emcy_type emcy_of(
		input dswi_pkg::dswi_fault_type f);
		dswi_pkg::dswi_emcy_type e;
		e.fault_num = 8'(f);
		unique case (f)
			dswi_pkg::no_fault: begin
				e.code = `DSWI_EC_NONE;
				e.err_reg = `DSWI_ER_NONE;
			end
			dswi_pkg::short_circuit_fault: begin
				e.code = `DSWI_EC_SHORT;
				e.err_reg = `DSWI_ER_CURR;
			end
			dswi_pkg::bus_overvoltage_fault: begin
				e.code = `DSWI_EC_BUS_OV;
				e.err_reg = `DSWI_ER_VOLT;
			end
			dswi_pkg::regeneration_fault: begin
				e.code = `DSWI_EC_REGEN;
				e.err_reg = `DSWI_ER_CURR;
			end
			dswi_pkg::ambient_overtemp_fault: begin
				e.code = `DSWI_EC_AMB_OT;
				e.err_reg = `DSWI_ER_TEMP;
			end
			dswi_pkg::bridge_overtemp_fault: begin
				e.code = `DSWI_EC_BRDG_OT;
				e.err_reg = `DSWI_ER_TEMP;
			end
			dswi_pkg::motor_overtemp_fault: begin
				e.code = `DSWI_EC_MOT_OT;
				e.err_reg = `DSWI_ER_TEMP;
			end
			dswi_pkg::position_encoder_fault: begin
				e.code = `DSWI_EC_ENC;
				e.err_reg = `DSWI_ER_GEN;
			end
			dswi_pkg::angle_resolver_fault: begin
				e.code = `DSWI_EC_RES;
				e.err_reg = `DSWI_ER_GEN;
			end
			default: begin
				e.code = `DSWI_EC_NONE;
				e.err_reg = `DSWI_ER_NONE;
			end
		endcase
		return e;
	endfunction

	// Status pattern of a state
	function automatic logic [15:0] status_of(
		input dswi_pkg::dswi_state_type s);
		logic [15:0] w;
		w = `DSWI_SW_NOT_READY;
		unique case (s)
			dswi_pkg::dswi_not_ready: w = `DSWI_SW_NOT_READY;
			dswi_pkg::dswi_so_disabled: w = `DSWI_SW_SO_DIS;
			dswi_pkg::dswi_ready: w = `DSWI_SW_READY;
			dswi_pkg::dswi_switched_on: w = `DSWI_SW_SWITCHED;
			dswi_pkg::dswi_op_enabled: w = `DSWI_SW_OP_EN;
			dswi_pkg::dswi_quick_stop: w = `DSWI_SW_QSTOP;
			dswi_pkg::dswi_fault_react: w = `DSWI_SW_FLT_REACT;
			dswi_pkg::dswi_fault: w = `DSWI_SW_FAULT;
		endcase
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic fr, eo, qs, ev, so;
	logic cmd_shutdown, cmd_switch_on, cmd_enable, cmd_dis_volt;
	logic cmd_qstop, cmd_fault_reset;

	// Bit 7 set overrides every other pattern
	always_comb begin
		fr = control_word[`DSWI_CW_FR];
		eo = control_word[`DSWI_CW_EO];
		qs = control_word[`DSWI_CW_QS];
		ev = control_word[`DSWI_CW_EV];
		so = control_word[`DSWI_CW_SO];
		cmd_fault_reset = cw_strobe && fr;
		cmd_dis_volt = cw_strobe && !fr && !ev;
		cmd_qstop = cw_strobe && !fr && ev && !qs;
		cmd_shutdown = cw_strobe && !fr && ev && qs && !so;
		cmd_switch_on = cw_strobe && !fr && ev && qs && so && !eo;
		cmd_enable = cw_strobe && !fr && ev && qs && so && eo;
	end

	// Mode selector classes
	always_comb begin
		mode_info.vendor = mode_sel < 0;
		mode_info.none = mode_sel == `DSWI_MODE_NONE;
		// Signed compare, or negative vendor modes would count as reserved
		mode_info.reserved = mode_sel == `DSWI_MODE_RSVD
			|| mode_sel > $signed(`DSWI_MODE_MAX);
		mode_info.defined = !mode_info.vendor && !mode_info.none
			&& !mode_info.reserved;
	end

	// ----------------------------------------------------------------
	// State and emergency registers
	// ----------------------------------------------------------------
	dswi_pkg::dswi_regs_type r, next_r;
	logic [NUM_FAULTS-1:0] new_faults;
	int first_idx;

	// New fault edges queue up; one emergency leaves per cycle
	always_comb begin
		next_r = r;
		next_r.emcy_valid = 1'b0;
		new_faults = fault_in & ~r.fault_pend[NUM_FAULTS-1:0];
		next_r.fault_pend[NUM_FAULTS-1:0] = fault_in;
		first_idx = 0;
		for (int i = NUM_FAULTS; i >= 1; i--) begin
			if (new_faults[i-1]) begin
				first_idx = i;
			end
		end
		if (first_idx != 0) begin
			next_r.emcy = emcy_of(dswi_pkg::dswi_fault_type'(first_idx));
			next_r.emcy_valid = 1'b1;
			// Only the lowest new fault is sent; others re-arm next cycle
			next_r.fault_pend[NUM_FAULTS-1:0] = fault_in & ~(new_faults
				& ~(NUM_FAULTS'(1) << (first_idx - 1)));
		end
		// Unlisted commands for a state leave it untouched
		unique case (r.state)
			dswi_pkg::dswi_not_ready: begin
				if (power_ready) begin
					next_r.state = dswi_pkg::dswi_so_disabled;
				end
			end
			dswi_pkg::dswi_so_disabled: begin
				if (cmd_shutdown) begin
					next_r.state = dswi_pkg::dswi_ready;
				end
			end
			dswi_pkg::dswi_ready: begin
				if (cmd_dis_volt || cmd_qstop) begin
					next_r.state = dswi_pkg::dswi_so_disabled;
				end else if (cmd_switch_on || cmd_enable) begin
					next_r.state = dswi_pkg::dswi_switched_on;
					next_r.pend_enable = cmd_enable;
				end
			end
			dswi_pkg::dswi_switched_on: begin
				next_r.pend_enable = 1'b0;
				if (cmd_dis_volt || cmd_qstop) begin
					next_r.state = dswi_pkg::dswi_so_disabled;
				end else if (cmd_shutdown) begin
					next_r.state = dswi_pkg::dswi_ready;
				end else if (cmd_enable || r.pend_enable) begin
					next_r.state = dswi_pkg::dswi_op_enabled;
				end
			end
			dswi_pkg::dswi_op_enabled: begin
				if (cmd_dis_volt) begin
					next_r.state = dswi_pkg::dswi_so_disabled;
				end else if (cmd_qstop) begin
					next_r.state = dswi_pkg::dswi_quick_stop;
				end else if (cmd_shutdown) begin
					next_r.state = dswi_pkg::dswi_ready;
				end else if (cmd_switch_on) begin
					next_r.state = dswi_pkg::dswi_switched_on;
				end
			end
			dswi_pkg::dswi_quick_stop: begin
				if (cmd_dis_volt) begin
					next_r.state = dswi_pkg::dswi_so_disabled;
				end else if (cmd_enable) begin
					next_r.state = dswi_pkg::dswi_op_enabled;
				end
			end
			dswi_pkg::dswi_fault_react: begin
				if (reaction_done) begin
					next_r.state = dswi_pkg::dswi_fault;
				end
			end
			dswi_pkg::dswi_fault: begin
				if (cmd_fault_reset && fault_in == '0) begin
					next_r.state = dswi_pkg::dswi_so_disabled;
				end
			end
		endcase
		// A new fault preempts any command outside the fault states
		if (first_idx != 0 && r.state != dswi_pkg::dswi_fault_react
			&& r.state != dswi_pkg::dswi_fault) begin
			next_r.state = dswi_pkg::dswi_fault_react;
			next_r.pend_enable = 1'b0;
		end
		next_r.status_word = status_of(next_r.state);
	end

	// State register
	always_ff @(posedge clock) begin
		if (!nrst) begin
			r <= '{state: dswi_pkg::dswi_not_ready, pend_enable: 1'b0,
				status_word: `DSWI_SW_NOT_READY,
				emcy: '{`DSWI_EC_NONE, `DSWI_ER_NONE, '0},
				emcy_valid: 1'b0, fault_pend: '0};
		end else begin
			r <= next_r;
		end
	end

	assign status_word = r.status_word;
	assign drive_state = r.state;
	assign emcy = r.emcy;
	assign emcy_valid = r.emcy_valid;

endmodule

// [rtl/dswi_defs.svh]
// Constants for the drive state word interface
`ifndef DSWI_DEFS_SVH
`define DSWI_DEFS_SVH

// ----------------------------------------------------------------
// Control word bit positions
// ----------------------------------------------------------------
`define DSWI_CW_SO 0
`define DSWI_CW_EV 1
`define DSWI_CW_QS 2
`define DSWI_CW_EO 3
`define DSWI_CW_FR 7

// ----------------------------------------------------------------
// Status word low bits (6,5,3..0 meaningful)
// ----------------------------------------------------------------
`define DSWI_SW_NOT_READY 16'h0000
`define DSWI_SW_SO_DIS 16'h0040
`define DSWI_SW_READY 16'h0021
`define DSWI_SW_SWITCHED 16'h0023
`define DSWI_SW_OP_EN 16'h0027
`define DSWI_SW_QSTOP 16'h0007
`define DSWI_SW_FLT_REACT 16'h000F
`define DSWI_SW_FAULT 16'h0008

// ----------------------------------------------------------------
// Operation mode selector limits
// ----------------------------------------------------------------
`define DSWI_MODE_NONE 8'h00
`define DSWI_MODE_RSVD 8'h05
`define DSWI_MODE_MAX 8'h0A

// ----------------------------------------------------------------
// Emergency codes and error register values
// ----------------------------------------------------------------
`define DSWI_EC_NONE 16'h0000
`define DSWI_EC_SHORT 16'h2340
`define DSWI_EC_BUS_OV 16'h3210
`define DSWI_EC_REGEN 16'h2310
`define DSWI_EC_AMB_OT 16'h4110
`define DSWI_EC_BRDG_OT 16'h4210
`define DSWI_EC_MOT_OT 16'h4310
`define DSWI_EC_ENC 16'h7305
`define DSWI_EC_RES 16'h7303
`define DSWI_ER_NONE 8'h00
`define DSWI_ER_CURR 8'h03
`define DSWI_ER_VOLT 8'h05
`define DSWI_ER_TEMP 8'h09
`define DSWI_ER_GEN 8'h01
`define DSWI_NUM_FAULTS 8

`endif

// [rtl/dswi_pkg.sv]
// Types for the drive state word interface
package dswi_pkg;

	typedef enum logic [2:0] {
		dswi_not_ready,
		dswi_so_disabled,
		dswi_ready,
		dswi_switched_on,
		dswi_op_enabled,
		dswi_quick_stop,
		dswi_fault_react,
		dswi_fault
	} dswi_state_type;

	typedef enum logic [3:0] {
		no_fault,
		short_circuit_fault,
		bus_overvoltage_fault,
		regeneration_fault,
		ambient_overtemp_fault,
		bridge_overtemp_fault,
		motor_overtemp_fault,
		position_encoder_fault,
		angle_resolver_fault
	} dswi_fault_type;

	typedef struct packed {
		logic [15:0] code;
		logic [7:0] err_reg;
		logic [7:0] fault_num;
	} dswi_emcy_type;

	typedef struct packed {
		logic vendor;
		logic none;
		logic defined;
		logic reserved;
	} dswi_mode_info_type;

	typedef struct packed {
		dswi_state_type state;
		logic pend_enable;
		logic [15:0] status_word;
		dswi_emcy_type emcy;
		logic emcy_valid;
		logic [7:0] fault_pend;
	} dswi_regs_type;

endpackage

// [bench/dswi_master.sv]
// Fieldbus master model that writes control words to the drive
module dswi_master (
	input wire logic clock, // Bench clock
	output logic [15:0] control_word, // Command word to the drive
	output logic cw_strobe // One-cycle write pulse
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus: no write pending
	initial begin
		control_word = 16'h0000;
		cw_strobe = 1'h0;
	end

	// One write: word held with the strobe for exactly one edge
	task automatic issue(input logic [15:0] v);
		@(posedge clock);
		control_word <= v;
		cw_strobe <= 1'h1;
		@(posedge clock);
		cw_strobe <= 1'h0;
		control_word <= ~v; // Released word must not look valid
	endtask
endmodule

// [bench/dswi_core_properties.sv]
// Port-level checker for the drive state word interface
module dswi_core_props #(
	parameter int NUM_FAULTS = 8
) (
	input wire logic clock, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic [15:0] control_word, // Command word
	input wire logic cw_strobe, // Command pulse
	input wire logic signed [7:0] mode_sel, // Mode selector
	input wire logic [NUM_FAULTS-1:0] fault_in, // Fault lines
	input wire logic [15:0] status_word, // Status word
	input wire dswi_pkg::dswi_state_type drive_state, // State
	input wire dswi_pkg::dswi_mode_info_type mode_info, // Mode flags
	input wire dswi_pkg::dswi_emcy_type emcy, // Emergency message
	input wire logic emcy_valid // Emergency pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	localparam logic [15:0] SWMAP [8] = '{16'h0000, 16'h0040, 16'h0021,
		16'h0023, 16'h0027, 16'h0007, 16'h000F, 16'h0008};
	wire cmd = cw_strobe && !control_word[7];
	wire [3:0] cw = control_word[3:0];
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	a_status_map: assert property (
		status_word == SWMAP[drive_state]) else $error("bad status word");
	// A new fault preempts any command, so the fault lines must stay quiet
	a_shutdown_cmd: assert property (
		cmd && cw[2:0] == 3'h6 && drive_state == dswi_pkg::dswi_so_disabled
		&& fault_in == '0 |=> drive_state == dswi_pkg::dswi_ready)
		else $error("no shutdown");
	a_combined_cmd: assert property (
		cmd && cw == 4'hF && drive_state == dswi_pkg::dswi_ready &&
		fault_in == '0 |=> drive_state == dswi_pkg::dswi_switched_on)
		else $error("no switch-on");
	a_auto_enable: assert property (
		cmd && cw == 4'hF && drive_state == dswi_pkg::dswi_ready &&
		fault_in == '0 ##1 !cw_strobe && fault_in == '0 |=>
		drive_state == dswi_pkg::dswi_op_enabled) else $error("no enable");
	a_ignore_cmd: assert property (
		cmd && cw == 4'hF && drive_state == dswi_pkg::dswi_so_disabled &&
		fault_in == '0 |=> $stable(status_word))
		else $error("invalid command acted on");
	a_fault_reset: assert property (
		cw_strobe && control_word[7] && fault_in == '0 &&
		drive_state == dswi_pkg::dswi_fault |=>
		drive_state == dswi_pkg::dswi_so_disabled) else $error("no reset");
	a_bus_ov_emcy: assert property (
		$rose(fault_in[1]) && !fault_in[0] |=> emcy_valid &&
		emcy == 32'h3210_0502) else $error("bad overvoltage message");
	a_temp_class: assert property (
		emcy_valid && emcy.code[15:12] == 4'h4 |-> emcy.err_reg == 8'h09)
		else $error("bad temperature register");
	a_mode_class: assert property (
		mode_info == {mode_sel < 0, mode_sel == 0, mode_sel > 0 &&
		mode_sel < 8'sh0B && mode_sel != 8'sh05, mode_sel == 8'sh05 ||
		mode_sel > 8'sh0A}) else $error("bad mode flags");
	// Main scenarios reached
	c_enabled: cover property (drive_state == dswi_pkg::dswi_op_enabled);
	c_emcy: cover property (emcy_valid);
	c_quick: cover property (drive_state == dswi_pkg::dswi_quick_stop);
	c_paired: cover property (emcy_valid ##1 emcy_valid);
endmodule

bind dswi_core dswi_core_props #(.NUM_FAULTS(NUM_FAULTS)) props_inst (
	.clock, .nrst, .control_word, .cw_strobe, .mode_sel, .fault_in,
	.status_word, .drive_state, .mode_info, .emcy, .emcy_valid);

// [bench/drive_state_word_interface_tb.sv]
// Self-checking testbench for the drive state word interface
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	fails++; $display("Error %s expected %h seen %h", n, e, g); end end
module drive_state_word_interface_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, nrst, cw_strobe, power_ready, reaction_done, emcy_valid;
	logic signed [7:0] mode_sel;
	logic [7:0] fault_in;
	logic [15:0] control_word, status_word;
	dswi_pkg::dswi_state_type drive_state;
	dswi_pkg::dswi_mode_info_type mode_info;
	dswi_pkg::dswi_emcy_type emcy;
	int fails = 0, checks_done = 0, cycles = 0;

	dswi_core #(.NUM_FAULTS(8)) dswi_core_inst (.clock, .nrst,
		.control_word, .cw_strobe, .mode_sel, .fault_in, .power_ready,
		.reaction_done, .status_word, .drive_state, .mode_info, .emcy,
		.emcy_valid);
	dswi_master dswi_master_inst (.clock, .control_word, .cw_strobe);
	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	// Step past n edges, then let their updates land
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic cmd(input logic [15:0] v);
		dswi_master_inst.issue(v);
		#1;
	endtask
	// State itself is tied to the status word by the checker
	task automatic sw(input logic [15:0] e);
		`CHK("status_word", e, status_word)
	endtask
	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	task automatic test_reset;
		sw(16'h0000);
		`CHK("emcy_valid", 1'h0, emcy_valid)
		cmd(16'h0006);
		sw(16'h0000);
		$display("test reset done");
	endtask
	// Table covers both ends of every mode class
	task automatic test_modes;
		logic signed [7:0] mv [8];
		logic [3:0] ex [8];
		mv = '{8'sh80, 8'shFF, 8'sh00, 8'sh01, 8'sh05, 8'sh0A, 8'sh0B, 8'sh7F};
		ex = '{4'h8, 4'h8, 4'h4, 4'h2, 4'h1, 4'h2, 4'h1, 4'h1};
		foreach (mv[i]) begin
			@(posedge clock) mode_sel <= mv[i];
			#1;
			`CHK("mode_info", ex[i], mode_info)
		end
		$display("test modes done");
	endtask
	task automatic test_bringup;
		@(posedge clock) power_ready <= 1'h1;
		settle(1);
		sw(16'h0040);
		cmd(16'h000F);
		sw(16'h0040);
		cmd(16'h0006);
		sw(16'h0021);
		cmd(16'h000F);
		sw(16'h0023);
		settle(1);
		sw(16'h0027);
		cmd(16'h0007);
		sw(16'h0023);
		cmd(16'h000F);
		sw(16'h0027);
		cmd(16'h000B);
		sw(16'h0007);
		cmd(16'h0006); // Shutdown has no exit from quick stop
		sw(16'h0007);
		cmd(16'h0000);
		sw(16'h0040);
		$display("test bringup done");
	endtask
	// Every fault number, each from switch-on-disabled and back
	task automatic test_faults;
		logic [31:0] em [8];
		em = '{32'h2340_0301, 32'h3210_0502, 32'h2310_0303, 32'h4110_0904,
			32'h4210_0905, 32'h4310_0906, 32'h7305_0107, 32'h7303_0108};
		for (int i = 0; i < 8; i++) begin
			@(posedge clock) fault_in <= 8'h01 << i;
			settle(1);
			`CHK("emcy_valid", 1'h1, emcy_valid)
			`CHK("emcy", em[i], emcy)
			sw(16'h000F);
			cmd(16'h0080);
			sw(16'h000F);
			`CHK("emcy_valid", 1'h0, emcy_valid)
			@(posedge clock) reaction_done <= 1'h1;
			settle(1);
			sw(16'h0008);
			cmd(16'h0080); // Fault still present: reset refused
			sw(16'h0008);
			@(posedge clock) begin
				reaction_done <= 1'h0;
				fault_in <= 8'h00;
			end
			cmd(16'h0080);
			sw(16'h0040);
		end
		$display("test faults done");
	endtask
	// Two faults at once: lower number first, the other one cycle later
	task automatic test_pairing;
		@(posedge clock) fault_in <= 8'h06;
		settle(1);
		`CHK("emcy", 32'h3210_0502, emcy)
		settle(1);
		`CHK("emcy_valid", 1'h1, emcy_valid)
		`CHK("emcy", 32'h2310_0303, emcy)
		sw(16'h000F);
		settle(1);
		`CHK("emcy_valid", 1'h0, emcy_valid)
		@(posedge clock) begin
			reaction_done <= 1'h1;
			fault_in <= 8'h00;
		end
		settle(1);
		sw(16'h0008);
		@(posedge clock) reaction_done <= 1'h0;
		cmd(16'h0080);
		sw(16'h0040);
		$display("test pairing done");
	endtask
	// -------------------------------------------------------------
	// Clock, watchdog and main sequence
	// -------------------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end
	// Whole run needs about 130 cycles; a hang is cut short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			print_verdict;
		end
	end
	initial begin
		nrst = 1'h0;
		power_ready = 1'h0;
		reaction_done = 1'h0;
		fault_in = 8'h00;
		mode_sel = 8'sh00;
		repeat (5) @(posedge clock);
		nrst <= 1'h1;
		#1;
		test_reset;
		test_modes;
		test_bringup;
		test_faults;
		test_pairing;
		print_verdict;
	end
endmodule
